// ### bench/debug_host_model.sv
// Serial debug host model; its clock stands still outside frames
`timescale 1ns/1ps
module debug_host_model (
	// Link pins
	output logic swd_clk,
	output logic swdio_in,
	input wire logic swdio_out,
	input wire logic swdio_oe
);
	initial begin
		swd_clk = 1'b0;
		swdio_in = 1'b0;
	end
	// One 32 ns link period, data set in the low phase
	task automatic tick(input logic b);
		swdio_in = b;
		#16 swd_clk = 1'b1;
		#16 swd_clk = 1'b0;
	endtask
	// Start, opcode and data LSB first, then collect the answer bits
	task automatic frame(input logic [3:0] op, input logic [31:0] d,
		output logic [32:0] r, output int n);
		n = 0;
		r = 33'h0;
		// Two idle clocks first let the link see the lock flag after reset
		tick(1'b0);
		tick(1'b0);
		tick(1'b1);
		for (int i = 0; i < 4; i++) tick(op[i]);
		for (int i = 0; i < 32; i++) tick(d[i]);
		for (int i = 0; i < 35; i++) begin
			// Released line toggles so a stale level is never read back
			swdio_in = (i < 33) ? ~swdio_in : 1'b0;
			#16;
			if (swdio_oe === 1'b1) begin
				r = {swdio_out, r[32:1]};
				n++;
			end
			swd_clk = 1'b1;
			#16 swd_clk = 1'b0;
		end
	endtask
endmodule

// ### bench/device_lockout_latch_assertions.sv
// Port checker for the device lockout latch
`timescale 1ns/1ps
module device_lockout_latch_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Firmware key port
	input wire logic fw_key_load,
	input wire logic fw_key_commit,
	input wire logic fw_key_done,
	input wire logic fw_key_refused,
	// Access gating
	input wire logic debug_mode_req,
	input wire logic test_mode_req,
	input wire logic debug_mode_grant,
	input wire logic test_mode_grant,
	input wire logic port_enable,
	input wire logic locked,
	input wire logic swdio_oe,
	// Flash controller
	input wire logic flash_req,
	input wire logic [1:0] flash_op,
	input wire logic [2:0] flash_blk,
	input wire logic flash_ack
);
	// The link side is judged through its pin enable on the core clock
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_key_req;
		fw_key_load || fw_key_commit;
	endsequence
	sequence s_one_answer;
		fw_key_done ^ fw_key_refused;
	endsequence
	a_key_answer: assert property (s_key_req |=> s_one_answer)
		else $error("key request without exactly one answer");
	a_key_quiet: assert property (!(fw_key_load || fw_key_commit)
		|=> !fw_key_done && !fw_key_refused)
		else $error("key answer without request");
	a_lock_block: assert property (
		locked && (fw_key_load || fw_key_commit) |=> fw_key_refused)
		else $error("key write accepted while locked");
	a_lock_ports: assert property (locked |-> !port_enable
		&& !debug_mode_grant && !test_mode_grant)
		else $error("access granted while locked");
	a_grant_gate: assert property (
		debug_mode_grant == (debug_mode_req && port_enable)
		&& test_mode_grant == (test_mode_req && port_enable))
		else $error("mode grant does not follow request and access");
	// The capture lands one edge after release, so the change is seen a
	// further edge later
	a_lock_held: assert property (
		$changed(locked) |-> $past(rst, 2))
		else $error("lock state changed outside reset");
	a_open_unlocked: assert property (
		!$past(rst) |-> port_enable == !locked)
		else $error("port enable disagrees with captured lock");
	a_link_mute: assert property (locked |-> !swdio_oe)
		else $error("link pin driven while locked");
	a_flash_shut: assert property (locked |-> !flash_req)
		else $error("flash request while locked");
	a_flash_hold: assert property (flash_req && !flash_ack
		|=> flash_req && $stable(flash_op) && $stable(flash_blk))
		else $error("flash request dropped before acknowledge");
endmodule

bind device_lockout_latch device_lockout_latch_assertions
	device_lockout_latch_assertions_inst (.clk(clk), .rst(rst),
	.fw_key_load(fw_key_load), .fw_key_commit(fw_key_commit),
	.fw_key_done(fw_key_done), .fw_key_refused(fw_key_refused),
	.debug_mode_req(debug_mode_req), .test_mode_req(test_mode_req),
	.debug_mode_grant(debug_mode_grant), .test_mode_grant(test_mode_grant),
	.port_enable(port_enable), .locked(locked), .swdio_oe(swdio_oe),
	.flash_req(flash_req), .flash_op(flash_op), .flash_blk(flash_blk),
	.flash_ack(flash_ack));

// ### bench/test_device_lockout_latch.sv
// Self-checking bench for the device lockout latch
`timescale 1ns/1ps
module test_device_lockout_latch;
	import lockout_pkg::*;
	localparam logic [31:0] K = 32'hA5C3_96E1; // Arbitrary, matches default
	logic clk, rst, por, swd_clk, swdio_in, swdio_out, swdio_oe;
	logic fw_key_load, fw_key_commit, fw_key_done, fw_key_refused;
	logic [31:0] fw_key_data;
	logic debug_mode_req, test_mode_req, debug_mode_grant, test_mode_grant;
	logic port_enable, locked, flash_req, flash_ack, flash_ok;
	logic [1:0] flash_op;
	logic [2:0] flash_blk;
	logic [23:0] flash_wdata;
	logic [28:0] fl_seen;
	logic fl_wait = 1'b0;
	int failures = 0;
	int cmp_count = 0;
	device_lockout_latch device_lockout_latch_inst (.clk(clk), .rst(rst),
		.por(por), .swd_clk(swd_clk), .swdio_in(swdio_in),
		.swdio_out(swdio_out), .swdio_oe(swdio_oe),
		.fw_key_load(fw_key_load), .fw_key_commit(fw_key_commit),
		.fw_key_data(fw_key_data), .fw_key_done(fw_key_done),
		.fw_key_refused(fw_key_refused), .debug_mode_req(debug_mode_req),
		.test_mode_req(test_mode_req), .debug_mode_grant(debug_mode_grant),
		.test_mode_grant(test_mode_grant), .port_enable(port_enable),
		.locked(locked), .flash_req(flash_req), .flash_op(flash_op),
		.flash_blk(flash_blk), .flash_wdata(flash_wdata),
		.flash_ack(flash_ack), .flash_ok(flash_ok));
	debug_host_model debug_host_model_inst (.swd_clk(swd_clk),
		.swdio_in(swdio_in), .swdio_out(swdio_out), .swdio_oe(swdio_oe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Flash stand-in: acknowledges one cycle after a request, so the
	// request is seen waiting for its acknowledge
	always @(posedge clk) begin
		#2;
		if (flash_req) fl_seen = {flash_op, flash_blk, flash_wdata};
		flash_ack = flash_req && fl_wait && !flash_ack;
		fl_wait = flash_req && !fl_wait;
	end
	task automatic summarize;
		if (failures == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input logic [32:0] g, input logic [32:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Reset held over two link clocks, then 12 more core cycles
	task automatic do_reset(input logic p);
		#2 rst = 1'b1;
		por = p;
		debug_host_model_inst.tick(1'b0);
		debug_host_model_inst.tick(1'b0);
		repeat (12) @(posedge clk);
		#2 rst = 1'b0;
		por = 1'b0;
		repeat (2) @(posedge clk);
		#2;
	endtask
	task automatic state(input logic lk);
		cmp(33'(locked), 33'(lk));
		cmp(33'(port_enable), 33'(!lk));
		cmp(33'({debug_mode_grant, test_mode_grant}),
			33'({2{!lk}}));
	endtask
	task automatic fw(input logic l, input logic c, input logic [31:0] d,
		input logic ok);
		@(posedge clk) #2;
		fw_key_load = l;
		fw_key_commit = c;
		fw_key_data = d;
		@(posedge clk) #2;
		fw_key_load = 1'b0;
		fw_key_commit = 1'b0;
		cmp(33'({fw_key_done, fw_key_refused}), 33'({ok, !ok}));
	endtask
	// Command frame, settle, then a NOP frame carrying its answer
	task automatic link(input logic [3:0] op, input logic [31:0] d,
		input logic [31:0] e);
		logic [32:0] r;
		int n;
		debug_host_model_inst.frame(op, d, r, n);
		repeat (12) @(posedge clk);
		debug_host_model_inst.frame(OP_NOP, 32'h0, r, n);
		cmp(r, {e, 1'b1});
		cmp(33'(n), 33'h21);
	endtask
	task automatic link_mute;
		logic [32:0] r;
		int n;
		debug_host_model_inst.frame(OP_READ_LATCH, 32'h0, r, n);
		cmp(33'(n), 33'h0);
	endtask
	initial begin
		{rst, por, flash_ok, debug_mode_req, test_mode_req} = 5'h1F;
		{fw_key_load, fw_key_commit} = 2'h0;
		fw_key_data = 32'h0;
		do_reset(1'b1);
		state(1'b0);
		fw(1'b1, 1'b0, K ^ 32'h0000_000F, 1'b1);
		fw(1'b0, 1'b1, 32'h0, 1'b1);
		state(1'b0);
		link(OP_READ_LATCH, 32'h0, K ^ 32'h0000_000F);
		do_reset(1'b0);
		state(1'b1);
		fw(1'b1, 1'b0, K, 1'b0);
		link_mute();
		do_reset(1'b1);
		fw(1'b1, 1'b0, K, 1'b1);
		do_reset(1'b0);
		state(1'b0);
		fw(1'b1, 1'b0, K ^ 32'h0000_001F, 1'b1);
		fw(1'b0, 1'b1, 32'h0, 1'b1);
		do_reset(1'b0);
		state(1'b0);
		do_reset(1'b1);
		link(OP_SET_PROT, 32'h0000_0001, ST_OK);
		fw(1'b1, 1'b0, K, 1'b0);
		link(OP_SET_PROT, 32'h0000_0000, ST_REFUSED);
		link(OP_ERASE_ALL, 32'h0, ST_OK);
		cmp(33'(fl_seen[28:27]), 33'(FOP_ERASE_ALL));
		fw(1'b1, 1'b0, K, 1'b1);
		link(OP_KEY_LOAD, K ^ 32'h0000_00FF, ST_OK);
		link(OP_KEY_COMMIT, 32'h0, ST_OK);
		link(OP_READ_LATCH, 32'h0, K ^ 32'h0000_00FF);
		link(OP_SET_PROT, 32'h0000_0100, ST_OK);
		link(OP_KEY_LOAD, K, ST_REFUSED);
		link(OP_READ_STATUS, 32'h0, 32'h0000_0100);
		link(OP_ERASE_BLK, 32'h0, ST_REFUSED);
		link(OP_PROGRAM_BLK, 32'h0, ST_REFUSED);
		link(OP_VERIFY_BLK, 32'h0, ST_REFUSED);
		link(OP_ERASE_BLK, 32'h1, ST_OK);
		link(OP_PROGRAM_BLK, 32'h1234_5601, ST_OK);
		cmp(33'(fl_seen), 33'({FOP_PROGRAM, 3'h1, 24'h123456}));
		link(OP_VERIFY_BLK, 32'h1, ST_OK);
		flash_ok = 1'b0;
		link(OP_VERIFY_BLK, 32'h1, ST_VERIFY_FAIL);
		link(4'hF, 32'h0, ST_BAD_OP);
		summarize();
	end
	// Watchdog well beyond the expected run
	initial begin
		#2000000;
		failures++;
		summarize();
	end
endmodule

// ### hdl/debug_link_port.sv
// Serial debug link front end, clocked by the host's debug clock
`timescale 1ns/1ps
module debug_link_port (
	// Link clock and reset
	input wire logic swd_clk,
	input wire logic rst,
	// Data pin
	input wire logic swdio_in,
	output logic swdio_out,
	output logic swdio_oe,
	// Core side
	latch_link_if.link lnk
);
	import lockout_pkg::*;

	logic [1:0] lock_s_r;
	logic resp_s1_r;
	logic resp_s2_r;
	logic resp_seen_r;
	logic [6:0] cnt_r;
	logic [3:0] op_r;
	logic [31:0] sh_r;
	logic [RESP_W-1:0] out_r;
	logic cmd_tgl_r;
	logic [3:0] cmd_op_r;
	logic [31:0] cmd_data_r;

	// Frame decode on the bit counter
	wire idle = (cnt_r == 7'h00);
	wire start = idle & swdio_in & ~lock_s_r[1];
	wire op_bit = (cnt_r >= CNT_OP_FIRST) && (cnt_r <= CNT_OP_LAST);
	wire data_bit = (cnt_r > CNT_OP_LAST) && (cnt_r <= CNT_IN_LAST);
	wire in_done = (cnt_r == CNT_IN_LAST);
	wire out_phase = (cnt_r > CNT_IN_LAST);
	wire [31:0] data_full = {swdio_in, sh_r[31:1]};
	wire new_resp = resp_s2_r ^ resp_seen_r;

	assign swdio_oe = out_phase;
	assign swdio_out = out_r[0];
	assign lnk.cmd_tgl = cmd_tgl_r;
	assign lnk.cmd_op = cmd_op_r;
	assign lnk.cmd_data = cmd_data_r;

	// Synchronisers; the link clock runs only during frames, which is
	// enough because the answer is sampled 36 edges into a frame
	always_ff @(posedge swd_clk or posedge rst) begin
		if (rst) begin
			lock_s_r <= 2'h3;
			resp_s1_r <= 1'b0;
			resp_s2_r <= 1'b0;
		end else begin
			lock_s_r <= {lock_s_r[0], lnk.lock};
			resp_s1_r <= lnk.resp_tgl;
			resp_s2_r <= resp_s1_r;
		end
	end

	// Frame counter and shift registers
	always_ff @(posedge swd_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 7'h00;
			op_r <= 4'h0;
			sh_r <= 32'h0000_0000;
		end else begin
			if (start || (!idle && cnt_r != CNT_FRAME_LAST))
				cnt_r <= cnt_r + 7'h01;
			else
				cnt_r <= 7'h00;
			if (op_bit)
				op_r <= {swdio_in, op_r[3:1]};
			if (data_bit)
				sh_r <= data_full;
		end
	end

	// Command hand-off and answer load at the end of the input phase
	always_ff @(posedge swd_clk or posedge rst) begin
		if (rst) begin
			cmd_tgl_r <= 1'b0;
			cmd_op_r <= OP_NOP;
			cmd_data_r <= 32'h0000_0000;
			resp_seen_r <= 1'b0;
			out_r <= '0;
		end else if (in_done) begin
			if (op_r != OP_NOP) begin
				cmd_tgl_r <= ~cmd_tgl_r;
				cmd_op_r <= op_r;
				cmd_data_r <= data_full;
			end
			out_r <= {lnk.resp_data, new_resp};
			resp_seen_r <= resp_s2_r;
		end else if (out_phase) begin
			out_r <= {1'b0, out_r[RESP_W-1:1]};
		end
	end
endmodule

// ### hdl/device_lockout_latch.sv
// Device lockout latch: key latch, reset capture, access and flash gating
`timescale 1ns/1ps
// Contract
// - Any latch word within 4 bits of the fixed 32-bit key can arm the lockout.
// - Lock output is one when at least 28 of 32 bits match the key.
// - While locked, refuse debug and test modes; all ports stay disabled.
// - Once the lock output is one, latch writes and commits are blocked.
// - Lock needs key load, commit to cells, then a reset, in that order.
// - Latch output is captured at reset and held until the next reset.
// - Key writes are accepted only while no flash protection is set.
// - After a key write, access stays open until the next reset.
// - Latch contents can be read over the serial debug link.
// - Protection can be raised by programming, lowered only by full erase.
// - Block erase, program, verify proceed only if block security allows.
// - The host can erase, program and verify the device over the link.
module device_lockout_latch #(
	parameter logic [31:0] LOCK_KEY = 32'hA5C3_96E1 // Arbitrary value
) (
	// Core clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	// Serial debug link pins
	input wire logic swd_clk,
	input wire logic swdio_in,
	output logic swdio_out,
	output logic swdio_oe,
	// Firmware key access
	input wire logic fw_key_load,
	input wire logic fw_key_commit,
	input wire logic [31:0] fw_key_data,
	output logic fw_key_done,
	output logic fw_key_refused,
	// Mode requests and port enables
	input wire logic debug_mode_req,
	input wire logic test_mode_req,
	output logic debug_mode_grant,
	output logic test_mode_grant,
	output logic port_enable,
	output logic locked,
	// Flash controller
	output logic flash_req,
	output logic [1:0] flash_op,
	output logic [lockout_pkg::BLK_W-1:0] flash_blk,
	output logic [lockout_pkg::PROG_DATA_W-1:0] flash_wdata,
	input wire logic flash_ack,
	input wire logic flash_ok
);
	import lockout_pkg::*;

	latch_link_if lnk ();

	ctl_state_t state_r, state_nxt;
	logic cmd_s1_r, cmd_s2_r, cmd_s3_r;
	logic lock_r, lock_nxt;
	logic cap_pend_r;
	logic [31:0] vol_key_r, vol_key_nxt;
	logic [31:0] cell_r, cell_nxt;
	logic [PROT_W-1:0] prot_lvl_r, prot_lvl_nxt;
	logic [NBLK-1:0] blk_prot_r, blk_prot_nxt;
	logic resp_tgl_r, resp_tgl_nxt;
	logic [31:0] resp_data_r, resp_data_nxt;
	logic flash_req_r, flash_req_nxt;
	logic [1:0] flash_op_r, flash_op_nxt;
	logic [BLK_W-1:0] flash_blk_r, flash_blk_nxt;
	logic [PROG_DATA_W-1:0] flash_wdata_r, flash_wdata_nxt;
	logic fw_done_r, fw_done_nxt;
	logic fw_ref_r, fw_ref_nxt;
	logic vote_out;

	// Latch wrapper: majority vote over the nonvolatile cells
	majority_vote #(
		.KEY(LOCK_KEY)
	) u_vote (
		.stored(cell_r),
		.match(vote_out)
	);

	// Link end on the host's clock
	debug_link_port u_link (
		.swd_clk(swd_clk),
		.rst(rst),
		.swdio_in(swdio_in),
		.swdio_out(swdio_out),
		.swdio_oe(swdio_oe),
		.lnk(lnk)
	);

	// Access decode; nothing opens until the reset capture is done
	wire access_ok = ~lock_r & ~cap_pend_r;
	wire prot_clear = (prot_lvl_r == PROT_NONE) && (blk_prot_r == '0);
	// Live vote also blocks: an armed latch is frozen even before reset
	wire key_wr_ok = ~vote_out & ~lock_r & prot_clear;
	wire cmd_ev = (cmd_s2_r ^ cmd_s3_r) & access_ok;
	wire [3:0] op = lnk.cmd_op;
	wire [31:0] cdata = lnk.cmd_data;
	wire [BLK_W-1:0] cblk = cdata[BLK_W-1:0];
	wire blk_open = ~blk_prot_r[cblk];
	wire [PROT_W-1:0] req_lvl = cdata[SET_PROT_LVL_LSB +: PROT_W];
	wire [NBLK-1:0] req_blk = cdata[SET_PROT_BLK_LSB +: NBLK];
	wire [31:0] status_word = {16'h0000, blk_prot_r, 3'h0,
		vote_out, prot_lvl_r, cap_pend_r, lock_r};

	assign lnk.resp_tgl = resp_tgl_r;
	assign lnk.resp_data = resp_data_r;
	assign lnk.lock = lock_r | cap_pend_r;
	assign locked = lock_r;
	assign port_enable = access_ok;
	assign debug_mode_grant = debug_mode_req & access_ok;
	assign test_mode_grant = test_mode_req & access_ok;
	assign flash_req = flash_req_r;
	assign flash_op = flash_op_r;
	assign flash_blk = flash_blk_r;
	assign flash_wdata = flash_wdata_r;
	assign fw_key_done = fw_done_r;
	assign fw_key_refused = fw_ref_r;

	// Command decode, latch writes, protection and flash sequencing
	always_comb begin
		state_nxt = state_r;
		vol_key_nxt = vol_key_r;
		cell_nxt = cell_r;
		prot_lvl_nxt = prot_lvl_r;
		blk_prot_nxt = blk_prot_r;
		resp_tgl_nxt = resp_tgl_r;
		resp_data_nxt = resp_data_r;
		flash_req_nxt = flash_req_r;
		flash_op_nxt = flash_op_r;
		flash_blk_nxt = flash_blk_r;
		flash_wdata_nxt = flash_wdata_r;
		fw_done_nxt = 1'b0;
		fw_ref_nxt = 1'b0;
		// Firmware key path; the link wins if both hit one cycle
		if (fw_key_load || fw_key_commit) begin
			if (key_wr_ok) begin
				fw_done_nxt = 1'b1;
				if (fw_key_load)
					vol_key_nxt = fw_key_data;
				else
					cell_nxt = vol_key_r;
			end else begin
				fw_ref_nxt = 1'b1;
			end
		end
		unique case (state_r)
			CTL_IDLE: begin
				if (cmd_ev) begin
					resp_tgl_nxt = ~resp_tgl_r;
					resp_data_nxt = ST_OK;
					case (op)
						OP_KEY_LOAD, OP_KEY_COMMIT: begin
							if (!key_wr_ok)
								resp_data_nxt = ST_REFUSED;
							else if (op == OP_KEY_LOAD)
								vol_key_nxt = cdata;
							else
								cell_nxt = vol_key_r;
						end
						OP_READ_LATCH: resp_data_nxt = cell_r;
						OP_READ_STATUS: resp_data_nxt = status_word;
						OP_SET_PROT: begin
							// Only raising is legal here
							if (req_lvl >= prot_lvl_r) begin
								prot_lvl_nxt = req_lvl;
								blk_prot_nxt = blk_prot_r | req_blk;
							end else begin
								resp_data_nxt = ST_REFUSED;
							end
						end
						OP_ERASE_ALL: begin
							resp_tgl_nxt = resp_tgl_r;
							flash_req_nxt = 1'b1;
							flash_op_nxt = FOP_ERASE_ALL;
							state_nxt = CTL_FLASH;
						end
						OP_ERASE_BLK, OP_PROGRAM_BLK, OP_VERIFY_BLK: begin
							if (blk_open) begin
								resp_tgl_nxt = resp_tgl_r;
								flash_req_nxt = 1'b1;
								flash_blk_nxt = cblk;
								flash_wdata_nxt =
									cdata[PROG_DATA_LSB +: PROG_DATA_W];
								if (op == OP_ERASE_BLK)
									flash_op_nxt = FOP_ERASE_BLK;
								else if (op == OP_PROGRAM_BLK)
									flash_op_nxt = FOP_PROGRAM;
								else
									flash_op_nxt = FOP_VERIFY;
								state_nxt = CTL_FLASH;
							end else begin
								resp_data_nxt = ST_REFUSED;
							end
						end
						default: resp_data_nxt = ST_BAD_OP;
					endcase
				end
			end
			CTL_FLASH: begin
				if (flash_ack) begin
					flash_req_nxt = 1'b0;
					resp_tgl_nxt = ~resp_tgl_r;
					resp_data_nxt = ST_OK;
					if (flash_op_r == FOP_VERIFY && !flash_ok)
						resp_data_nxt = ST_VERIFY_FAIL;
					// Protection is only cleared by a finished full erase
					if (flash_op_r == FOP_ERASE_ALL) begin
						prot_lvl_nxt = PROT_NONE;
						blk_prot_nxt = '0;
					end
					state_nxt = CTL_IDLE;
				end
			end
		endcase
	end

	// Latch output taken once, right after reset release; a later commit
	// changes nothing until the next reset
	always_comb begin
		lock_nxt = lock_r;
		if (cap_pend_r)
			lock_nxt = vote_out;
	end

	// Command toggle synchroniser; stage one feeds stage two only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_s1_r <= 1'b0;
			cmd_s2_r <= 1'b0;
			cmd_s3_r <= 1'b0;
		end else begin
			cmd_s1_r <= lnk.cmd_tgl;
			cmd_s2_r <= cmd_s1_r;
			cmd_s3_r <= cmd_s2_r;
		end
	end

	// Captured lock: fail-safe locked while reset is held
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_r <= 1'b1;
			cap_pend_r <= 1'b1;
		end else begin
			lock_r <= lock_nxt;
			cap_pend_r <= 1'b0;
		end
	end

	// Volatile control state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= CTL_IDLE;
			vol_key_r <= 32'h0000_0000;
			resp_tgl_r <= 1'b0;
			resp_data_r <= 32'h0000_0000;
			flash_req_r <= 1'b0;
			flash_op_r <= FOP_ERASE_ALL;
			flash_blk_r <= '0;
			flash_wdata_r <= '0;
			fw_done_r <= 1'b0;
			fw_ref_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			vol_key_r <= vol_key_nxt;
			resp_tgl_r <= resp_tgl_nxt;
			resp_data_r <= resp_data_nxt;
			flash_req_r <= flash_req_nxt;
			flash_op_r <= flash_op_nxt;
			flash_blk_r <= flash_blk_nxt;
			flash_wdata_r <= flash_wdata_nxt;
			fw_done_r <= fw_done_nxt;
			fw_ref_r <= fw_ref_nxt;
		end
	end

	// Nonvolatile cells and protection survive rst; only power-on clears
	always_ff @(posedge clk or posedge por) begin
		if (por) begin
			cell_r <= CELL_POR_VALUE;
			prot_lvl_r <= PROT_NONE;
			blk_prot_r <= '0;
		end else begin
			cell_r <= cell_nxt;
			prot_lvl_r <= prot_lvl_nxt;
			blk_prot_r <= blk_prot_nxt;
		end
	end
endmodule

// ### hdl/latch_link_if.sv
// Crossing signals between the debug link logic and the core logic
`timescale 1ns/1ps
interface latch_link_if;
	logic cmd_tgl;
	logic [3:0] cmd_op;
	logic [31:0] cmd_data;
	logic resp_tgl;
	logic [31:0] resp_data;
	logic lock;

	modport link (
		output cmd_tgl,
		output cmd_op,
		output cmd_data,
		input resp_tgl,
		input resp_data,
		input lock
	);
	modport core (
		input cmd_tgl,
		input cmd_op,
		input cmd_data,
		output resp_tgl,
		output resp_data,
		output lock
	);
endinterface

// ### hdl/lockout_pkg.sv
// Shared constants and types for the device lockout latch
package lockout_pkg;
	// Latch word and majority vote
	localparam int KEY_W = 32;
	localparam int VOTE_CNT_W = 6;
	localparam logic [5:0] VOTE_MIN = 6'h1C;
	localparam logic [31:0] CELL_POR_VALUE = 32'h0000_0000;

	// Debug link frame: start, opcode, data in, then answer out
	localparam int OP_W = 4;
	localparam logic [6:0] CNT_OP_FIRST = 7'h01;
	localparam logic [6:0] CNT_OP_LAST = 7'h04;
	localparam logic [6:0] CNT_IN_LAST = 7'h24;
	localparam logic [6:0] CNT_FRAME_LAST = 7'h45;
	localparam int RESP_W = 33;

	// Link opcodes
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_KEY_LOAD = 4'h1;
	localparam logic [3:0] OP_KEY_COMMIT = 4'h2;
	localparam logic [3:0] OP_READ_LATCH = 4'h3;
	localparam logic [3:0] OP_READ_STATUS = 4'h4;
	localparam logic [3:0] OP_SET_PROT = 4'h5;
	localparam logic [3:0] OP_ERASE_ALL = 4'h6;
	localparam logic [3:0] OP_ERASE_BLK = 4'h7;
	localparam logic [3:0] OP_PROGRAM_BLK = 4'h8;
	localparam logic [3:0] OP_VERIFY_BLK = 4'h9;

	// Answer status codes in the low bits of the answer word
	localparam logic [31:0] ST_OK = 32'h0000_0000;
	localparam logic [31:0] ST_REFUSED = 32'h0000_0001;
	localparam logic [31:0] ST_BAD_OP = 32'h0000_0002;
	localparam logic [31:0] ST_VERIFY_FAIL = 32'h0000_0003;

	// Flash protection
	localparam int NBLK = 8;
	localparam int BLK_W = 3;
	localparam int PROT_W = 2;
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam int SET_PROT_LVL_LSB = 0;
	localparam int SET_PROT_BLK_LSB = 8;
	localparam int PROG_DATA_LSB = 8;
	localparam int PROG_DATA_W = 24;

	// Flash controller operation codes
	localparam logic [1:0] FOP_ERASE_ALL = 2'h0;
	localparam logic [1:0] FOP_ERASE_BLK = 2'h1;
	localparam logic [1:0] FOP_PROGRAM = 2'h2;
	localparam logic [1:0] FOP_VERIFY = 2'h3;

	typedef enum logic [1:0] {
		CTL_IDLE = 2'b01,
		CTL_FLASH = 2'b10
	} ctl_state_t;
endpackage

// ### hdl/majority_vote.sv
// Super-majority comparator of the stored latch word against the key
`timescale 1ns/1ps
module majority_vote #(
	parameter logic [31:0] KEY = 32'h0000_0000
) (
	// Stored word and vote result
	input wire logic [31:0] stored,
	output logic match
);
	import lockout_pkg::*;

	logic [KEY_W-1:0] bit_eq;
	logic [VOTE_CNT_W-1:0] eq_cnt;

	// Per-bit agreement with the key
	genvar gi;
	generate
		for (gi = 0; gi < KEY_W; gi++) begin : g_eq
			assign bit_eq[gi] = (stored[gi] == KEY[gi]);
		end
	endgenerate

	// Sum of agreeing bits; a few weak cells cannot drop the lock
	always_comb begin
		eq_cnt = '0;
		for (int i = 0; i < KEY_W; i++) begin
			eq_cnt = eq_cnt + VOTE_CNT_W'(bit_eq[i]);
		end
	end

	assign match = (eq_cnt >= VOTE_MIN);
endmodule
